// ===== sdpr_pkg.sv
// sdpr_pkg: register map, field layout and enumerations of the sdram power block
package sdpr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  ADDR_SRR   = 8'h00; // self_refresh_request
  localparam logic [7:0]  ADDR_LPR   = 8'h04; // low_power_control
  localparam logic [7:0]  ADDR_IER   = 8'h08; // irq_enable
  localparam logic [7:0]  ADDR_IDR   = 8'h0c; // irq_disable
  localparam logic [7:0]  ADDR_IMR   = 8'h10; // irq_mask
  localparam logic [7:0]  ADDR_ISR   = 8'h14; // irq_status
  localparam logic [7:0]  ADDR_CFG   = 8'h18; // exit delay config
  localparam logic [7:0]  ADDR_TMR   = 8'h1c; // refresh timer count
  localparam logic [7:0]  ADDR_MODE  = 8'h20; // link mode status
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          CMD_BIT    = 0;     // self_refresh_cmd_bit, low_power_cmd_bit, res bit
  localparam int          XSR_W      = 4;
  localparam int          TMR_W      = 12;
  localparam int          CNT_W      = 5;
  localparam logic [3:0]  XSR_RST    = 4'h5;
  localparam logic [11:0] TMR_RST    = 12'h800;
  localparam logic        LPR_RST    = 1'b0;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  // ----------------------------------------------------------------
  // sdram commands and link states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDPR_NOP, SDPR_ACTIVATE, SDPR_READWRITE, SDPR_PRECHARGE,
    SDPR_REFRESH, SDPR_SELF_REFRESH, SDPR_POWER_DOWN
  } sdpr_cmd_type;
  typedef enum logic [2:0] {
    SDPR_IDLE, SDPR_REF, SDPR_SELF, SDPR_PD, SDPR_EXIT,
    SDPR_ACT, SDPR_BURST, SDPR_PRE
  } sdpr_state_type;
endpackage

// ===== sdpr_ctrl.sv
// sdpr_ctrl: sdram self-refresh, low-power and refresh-error logic with apb registers
//
// Behaviour
// R1 - wait programmed exit delay from clock enable high to activate
// R2 - exit delay field zero still gives half a clock period
// R3 - exit delay field resets to five cycles
// R4 - self-refresh write issues command, stops clock, drops clock enable
// R5 - access during self-refresh wakes the memory first, no software help
// R6 - low-power bit zero never issues a power-down command
// R7 - low-power bit one issues power-down after every burst
// R8 - low-power mode left on new access, re-entered after it
// R9 - enable write of one sets the refresh-error mask
// R10 - disable write of one clears the refresh-error mask
// R11 - mask register reads one when refresh-error irq enabled
// R12 - status bit shows refresh error since last read; read clears
// R13 - twelve-bit timer reloaded from count makes refresh pulses
// R14 - irq high while status and mask set; error is unserviced refresh
//
// Added by the designer: the APB interface to the registers and the placing of the registers.

// ------------------------------------------------------------------
// three-stage synchroniser, value accepted once stages two and three agree
// ------------------------------------------------------------------
module sdpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  // stage chain and agreement filter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // whole word at once, so a multi-bit field never shows a torn mix
      if (s2_q == s3_q) begin
        q_out <= s3_q;
      end
    end
  end
endmodule // sdpr_sync

module sdpr_ctrl #(
  parameter int BURST_TICKS = 8, // link ticks a burst occupies
  parameter int REF_TICKS   = 8  // link ticks a refresh occupies
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       link_clk_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [sdpr_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic                       acc_req_in,
  output logic                            acc_busy_out,
  output logic                            acc_done_out,
  output logic                            irq_out,
  output logic                            mem_clock_out,
  output logic                            mem_clock_enable_out,
  output sdpr_pkg::sdpr_cmd_type          mem_cmd_out
);
  import sdpr_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a <= ADDR_MODE) && (a[1:0] == 2'b00);
  endfunction

  // exit delay in link ticks, one tick per half memory clock
  function automatic logic [CNT_W-1:0] xsr_ticks(input logic [XSR_W-1:0] x);
    if (x == '0) begin
      xsr_ticks = CNT_W'(1);
    end else begin
      xsr_ticks = {x, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------
  // core domain: apb slave
  // ----------------------------------------------------------------
  logic             lp_q, mask_q, stat_q, armed_q, ref_pend, ref_pulse, err_ev;
  logic [XSR_W-1:0] xsr_q;
  logic [TMR_W-1:0] tcnt_q, timer_q;
  logic             sr_tgl_q, ref_tgl_q, acc_tgl_q;
  logic [3:0]       back_s;  // {mode[1:0], acc_ack, ref_ack}
  logic             setup, fire, wr, rd;
  logic [31:0]      rd_word;

  assign setup = psel_in && !penable_in;
  assign fire  = psel_in && penable_in && pready_out;
  assign wr    = fire && pwrite_in && !pslverr_out;
  assign rd    = fire && !pwrite_in && !pslverr_out;

  // read mux
  always_comb begin
    rd_word = ZERO_WORD;
    if (paddr_in == ADDR_LPR) begin
      rd_word[CMD_BIT] = lp_q;
    end else if (paddr_in == ADDR_IMR) begin
      rd_word[CMD_BIT] = mask_q; // [R11]
    end else if (paddr_in == ADDR_ISR) begin
      rd_word[CMD_BIT] = stat_q; // [R12]
    end else if (paddr_in == ADDR_CFG) begin
      rd_word[XSR_W-1:0] = xsr_q;
    end else if (paddr_in == ADDR_TMR) begin
      rd_word[TMR_W-1:0] = tcnt_q;
    end else if (paddr_in == ADDR_MODE) begin
      rd_word[1:0] = back_s[3:2];
    end
  end

  // one wait-free answer: ready and data prepared in setup
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= ZERO_WORD;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !is_mapped(paddr_in);
      if (setup) begin
        prdata_out <= pwrite_in ? ZERO_WORD : rd_word;
      end
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lp_q  <= LPR_RST;
      xsr_q <= XSR_RST; // [R3]
    end else if (wr && paddr_in == ADDR_LPR) begin
      lp_q <= pwdata_in[CMD_BIT];
    end else if (wr && paddr_in == ADDR_CFG) begin
      xsr_q <= pwdata_in[XSR_W-1:0];
    end
  end

  // self-refresh request: a one only flips the event toggle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sr_tgl_q <= 1'b0;
    end else if (wr && paddr_in == ADDR_SRR && pwdata_in[CMD_BIT]) begin
      sr_tgl_q <= !sr_tgl_q; // [R4]
    end
  end

  // interrupt mask: enable sets, disable clears, zeros ignored
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= 1'b0;
    end else if (wr && paddr_in == ADDR_IER && pwdata_in[CMD_BIT]) begin
      mask_q <= 1'b1; // [R9]
    end else if (wr && paddr_in == ADDR_IDR && pwdata_in[CMD_BIT]) begin
      mask_q <= 1'b0; // [R10]
    end
  end

  // refresh timer; refresh stays off until the count is written
  assign ref_pulse = armed_q && (timer_q == '0);
  assign ref_pend  = ref_tgl_q != back_s[0];
  assign err_ev    = ref_pulse && ref_pend; // [R14]
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tcnt_q    <= TMR_RST;
      timer_q   <= TMR_RST;
      armed_q   <= 1'b0;
      ref_tgl_q <= 1'b0;
    end else begin
      if (wr && paddr_in == ADDR_TMR) begin
        tcnt_q  <= pwdata_in[TMR_W-1:0];
        timer_q <= pwdata_in[TMR_W-1:0];
        armed_q <= 1'b1;
      end else if (ref_pulse) begin
        timer_q <= tcnt_q; // [R13]
      end else if (armed_q) begin
        timer_q <= timer_q - 1'b1;
      end
      if (ref_pulse && !ref_pend) begin
        ref_tgl_q <= !ref_tgl_q; // [R13]
      end
    end
  end

  // status: set wins over clear-on-read; irq from status and mask
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_q  <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (err_ev) begin
        stat_q <= 1'b1; // [R12]
      end else if (rd && paddr_in == ADDR_ISR) begin
        stat_q <= 1'b0; // [R12]
      end
      irq_out <= stat_q && mask_q; // [R14]
    end
  end

  // access handshake toward the link
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_tgl_q    <= 1'b0;
      acc_busy_out <= 1'b0;
      acc_done_out <= 1'b0;
    end else begin
      acc_done_out <= acc_busy_out && (back_s[1] == acc_tgl_q);
      if (!acc_busy_out && acc_req_in) begin
        acc_tgl_q    <= !acc_tgl_q;
        acc_busy_out <= 1'b1;
      end else if (acc_busy_out && back_s[1] == acc_tgl_q) begin
        acc_busy_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic             lr1_q, lrst_n;
  logic [7:0]       fwd_s;   // {xsr[3:0], lp, acc, ref, sr}
  logic             sr_seen_q, ref_ack_q, acc_ack_q, run_q;
  logic [1:0]       mode_q;
  logic [CNT_W-1:0] cnt_q, exit_n_q;
  logic             sr_ev, ref_ev, acc_ev, any_ev;
  sdpr_state_type   st_q;

  // reset release aligned to the link clock
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lr1_q  <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lr1_q  <= 1'b1;
      lrst_n <= lr1_q;
    end
  end

  sdpr_sync #(.W(8)) u_fwd (
    .clk_in   (link_clk_in),
    .rst_n_in (lrst_n),
    .d_in     ({xsr_q, lp_q, acc_tgl_q, ref_tgl_q, sr_tgl_q}),
    .q_out    (fwd_s)
  );
  sdpr_sync #(.W(4)) u_back (
    .clk_in   (core_clk_in),
    .rst_n_in (reset_n_in),
    .d_in     ({mode_q, acc_ack_q, ref_ack_q}),
    .q_out    (back_s)
  );

  assign sr_ev  = fwd_s[0] != sr_seen_q;
  assign ref_ev = fwd_s[1] != ref_ack_q;
  assign acc_ev = fwd_s[2] != acc_ack_q;
  assign any_ev = sr_ev || ref_ev || acc_ev;

  // memory command sequencer
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      st_q                 <= SDPR_IDLE;
      mem_cmd_out          <= SDPR_NOP;
      mem_clock_enable_out <= 1'b1;
      run_q                <= 1'b1;
      cnt_q                <= '0;
      sr_seen_q            <= 1'b0;
      ref_ack_q            <= 1'b0;
      acc_ack_q            <= 1'b0;
    end else begin
      mem_cmd_out <= SDPR_NOP;
      case (st_q)
        SDPR_IDLE: begin
          if (ref_ev) begin
            mem_cmd_out <= SDPR_REFRESH;
            cnt_q       <= CNT_W'(REF_TICKS - 1);
            st_q        <= SDPR_REF;
          end else if (sr_ev) begin
            mem_cmd_out          <= SDPR_SELF_REFRESH; // [R4]
            mem_clock_enable_out <= 1'b0;
            run_q                <= 1'b0;
            sr_seen_q            <= fwd_s[0];
            st_q                 <= SDPR_SELF;
          end else if (acc_ev) begin
            mem_cmd_out <= SDPR_ACTIVATE;
            st_q        <= SDPR_ACT;
          end
        end
        SDPR_REF: begin
          if (cnt_q == '0) begin
            ref_ack_q <= fwd_s[1];
            st_q      <= SDPR_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SDPR_SELF: begin
          // memory refreshes itself, so timer pulses are absorbed
          if (ref_ev) begin
            ref_ack_q <= fwd_s[1];
          end
          if (acc_ev) begin
            mem_clock_enable_out <= 1'b1; // [R5]
            run_q                <= 1'b1;
            cnt_q                <= xsr_ticks(fwd_s[7:4]) - 1'b1; // [R1] [R2]
            st_q                 <= SDPR_EXIT;
          end
        end
        SDPR_PD: begin
          if (any_ev) begin
            mem_clock_enable_out <= 1'b1; // [R8]
            cnt_q                <= xsr_ticks(fwd_s[7:4]) - 1'b1;
            st_q                 <= SDPR_EXIT;
          end
        end
        SDPR_EXIT: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1; // [R1]
          end else if (acc_ev) begin
            mem_cmd_out <= SDPR_ACTIVATE; // [R5]
            st_q        <= SDPR_ACT;
          end else begin
            st_q <= SDPR_IDLE;
          end
        end
        SDPR_ACT: begin
          mem_cmd_out <= SDPR_READWRITE;
          cnt_q       <= CNT_W'(BURST_TICKS - 1);
          st_q        <= SDPR_BURST;
        end
        SDPR_BURST: begin
          if (cnt_q == '0) begin
            mem_cmd_out <= SDPR_PRECHARGE;
            acc_ack_q   <= fwd_s[2];
            st_q        <= SDPR_PRE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SDPR_PRE: begin
          if (fwd_s[3]) begin
            mem_cmd_out          <= SDPR_POWER_DOWN; // [R7] [R8]
            mem_clock_enable_out <= 1'b0;
            st_q                 <= SDPR_PD;
          end else begin
            st_q <= SDPR_IDLE; // [R6]
          end
        end
        default: begin
          st_q <= SDPR_IDLE;
        end
      endcase
    end
  end

  // memory clock: half the link clock, held low while stopped
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      mem_clock_out <= 1'b0;
      mode_q        <= 2'b00;
      exit_n_q      <= '0;
    end else begin
      mem_clock_out <= run_q ? !mem_clock_out : 1'b0; // [R4]
      mode_q        <= {st_q == SDPR_SELF, st_q == SDPR_PD};
      exit_n_q      <= (st_q == SDPR_EXIT) ? exit_n_q + 1'b1 : '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_burst_end;
    st_q == SDPR_BURST && cnt_q == '0 ##1 st_q == SDPR_PRE;
  endsequence

  a_mask_set: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R9]
    wr && paddr_in == ADDR_IER && pwdata_in[CMD_BIT] |=> mask_q)
    else $error("mask not set by enable write");
  a_mask_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R10]
    wr && paddr_in == ADDR_IDR && pwdata_in[CMD_BIT] |=> !mask_q)
    else $error("mask not cleared by disable write");
  a_mask_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R11]
    rd && paddr_in == ADDR_IMR |-> prdata_out[CMD_BIT] == $past(mask_q))
    else $error("mask read value wrong");
  a_status_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R12]
    rd && paddr_in == ADDR_ISR |=> stat_q == $past(err_ev))
    else $error("status not cleared by read");
  a_status_irq: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R14]
    err_ev |=> stat_q ##1 (irq_out == $past(mask_q)))
    else $error("refresh error not flagged");
  a_timer_reload: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R13]
    ref_pulse && !wr |=> timer_q == $past(tcnt_q))
    else $error("refresh timer not reloaded");
  a_exit_delay: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [R1] [R2]
    st_q == SDPR_EXIT && cnt_q == '0 |-> exit_n_q + 1'b1 == xsr_ticks(fwd_s[7:4]))
    else $error("exit delay length wrong");
  a_self_ref_hold: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [R4]
    st_q == SDPR_SELF |-> !mem_clock_enable_out && !run_q ##1 !mem_clock_out)
    else $error("clock running in self-refresh");
  a_no_power_down: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [R6]
    s_burst_end ##0 !fwd_s[3] |=> mem_cmd_out != SDPR_POWER_DOWN && st_q == SDPR_IDLE)
    else $error("power-down issued while disabled");
  a_power_after: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [R7] [R8]
    s_burst_end ##0 fwd_s[3] |=> st_q == SDPR_PD && !mem_clock_enable_out)
    else $error("no power-down after burst");
endmodule // sdpr_ctrl

// ===== sdpr_mem_model.sv
// sdpr_mem_model: behavioural sdram watching clock, clock enable and command pins
module sdpr_mem_model (
  input  wire logic                   link_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   mem_clock_in,
  input  wire logic                   mem_clock_enable_in,
  input  wire sdpr_pkg::sdpr_cmd_type mem_cmd_in,
  output logic [7:0]                  gap_out,
  output logic [7:0]                  n_act_out,
  output logic [7:0]                  n_pd_out,
  output logic [7:0]                  n_sr_out,
  output logic [7:0]                  n_ref_out,
  output logic [7:0]                  n_tog_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdpr_pkg::*;
  // ----------------------------------------------------------------
  // pin history
  // ----------------------------------------------------------------
  logic       cke_q;
  logic       clk_q;
  logic       in_sr_q;
  logic       waking_q;
  logic [7:0] cnt_q;
  logic       rise;
  assign rise = mem_clock_enable_in && !cke_q;
  // link cycles from clock enable rise to activate
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cke_q    <= 1'b1;
      cnt_q    <= 8'h00;
      waking_q <= 1'b0;
      gap_out  <= 8'h00;
    end else begin
      cke_q <= mem_clock_enable_in;
      cnt_q <= rise ? 8'h01 : cnt_q + 8'h01;
      if (mem_cmd_in == SDPR_ACTIVATE && (waking_q || rise)) begin
        gap_out  <= rise ? 8'h00 : cnt_q;
        waking_q <= 1'b0;
      end else if (rise) begin
        waking_q <= 1'b1;
      end
    end
  end
  // command counters, seen one link cycle late
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      n_act_out <= 8'h00;
      n_pd_out  <= 8'h00;
      n_sr_out  <= 8'h00;
      n_ref_out <= 8'h00;
    end else begin
      if (mem_cmd_in == SDPR_ACTIVATE) n_act_out <= n_act_out + 8'h01;
      if (mem_cmd_in == SDPR_POWER_DOWN) n_pd_out <= n_pd_out + 8'h01;
      if (mem_cmd_in == SDPR_SELF_REFRESH) n_sr_out <= n_sr_out + 8'h01;
      if (mem_cmd_in == SDPR_REFRESH) n_ref_out <= n_ref_out + 8'h01;
    end
  end
  // memory clock rising edges while in self-refresh, must stay zero
  // the final fall as the clock stops low is not a toggle of the memory
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_q     <= 1'b0;
      in_sr_q   <= 1'b0;
      n_tog_out <= 8'h00;
    end else begin
      clk_q <= mem_clock_in;
      if (mem_cmd_in == SDPR_SELF_REFRESH) begin
        in_sr_q   <= 1'b1;
        n_tog_out <= 8'h00;
      end else if (rise) begin
        in_sr_q <= 1'b0;
      end else if (in_sr_q && mem_clock_in && !clk_q) begin
        n_tog_out <= n_tog_out + 8'h01;
      end
    end
  end
endmodule // sdpr_mem_model

// ===== sdpr_ctrl_tb.sv
// sdpr_ctrl_tb: register, self-refresh, low-power and refresh-error tests
module sdpr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdpr_pkg::*;
  logic         core_clk = 1'b0;
  logic         link_clk = 1'b0;
  logic         reset_n  = 1'b0;
  logic         psel     = 1'b0;
  logic         penable  = 1'b0;
  logic         pwrite   = 1'b0;
  logic         acc_req  = 1'b0;
  logic [7:0]   paddr    = 8'h00;
  logic [31:0]  pwdata   = 32'h0;
  logic [31:0]  prdata, rdata;
  logic         pready, pslverr, perr, busy, done, irq, mclk, cke;
  sdpr_cmd_type cmd;
  logic [7:0]   gap, n_act, n_pd, n_sr, n_ref, n_tog, pd0;
  int           n_fail   = 0;
  int           compares = 0;
  // core clock 4 ns, link clock 125 ns, free phase
  always #2 core_clk = ~core_clk;
  always #62.5 link_clk = ~link_clk;
  sdpr_ctrl #(.BURST_TICKS(8), .REF_TICKS(8)) u_dut (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .link_clk_in(link_clk),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .acc_req_in(acc_req), .acc_busy_out(busy), .acc_done_out(done), .irq_out(irq),
    .mem_clock_out(mclk), .mem_clock_enable_out(cke), .mem_cmd_out(cmd));
  sdpr_mem_model u_mem (
    .link_clk_in(link_clk), .reset_n_in(reset_n), .mem_clock_in(mclk),
    .mem_clock_enable_in(cke), .mem_cmd_in(cmd), .gap_out(gap), .n_act_out(n_act),
    .n_pd_out(n_pd), .n_sr_out(n_sr), .n_ref_out(n_ref), .n_tog_out(n_tog));
  // ----------------------------------------------------------------
  // compare, bus and access tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rdata = prdata;
    perr  = pslverr;
    if (i >= 50) chk_bit("pready", 1'b1, 1'b0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk_reg(name, exp, rdata);
  endtask
  // memory access: request until taken, then wait for the done pulse
  task automatic access;
    int i;
    @(posedge core_clk);
    acc_req <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (busy !== 1'b1 && i < 100);
    acc_req <= 1'b0;
    while (done !== 1'b1 && i < 8000) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 8000) chk_bit("acc_done", 1'b1, 1'b0);
    repeat (100) @(posedge core_clk);
  endtask
  // self-refresh entry, then wake by access and measure exit delay
  task automatic sr_cycle(input logic [3:0] fld, input logic set);
    logic [7:0] sr0, act0, exp;
    exp = (fld == 4'h0) ? 8'h01 : {3'b000, fld, 1'b0};
    if (set) wr(ADDR_CFG, {28'h0, fld});
    sr0  = n_sr;
    act0 = n_act;
    wr(ADDR_SRR, 32'h0);
    repeat (400) @(posedge core_clk);
    chk_reg("sr_zero", sr0, n_sr);
    wr(ADDR_SRR, 32'h1);
    repeat (400) @(posedge core_clk);
    chk_reg("sr_cmd", sr0 + 8'h01, n_sr);
    chk_bit("sr_cke", 1'b0, cke);
    chk_reg("sr_clock_edges", 32'h0, n_tog);
    rd_chk("mode_sr", ADDR_MODE, 32'h2);
    access();
    chk_reg("sr_wake_act", act0 + 8'h01, n_act);
    chk_bit("sr_wake_cke", 1'b1, cke);
    chk_reg("exit_gap", exp, gap);
  endtask
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk("lpr_rst", ADDR_LPR, 32'h0);
    rd_chk("imr_rst", ADDR_IMR, 32'h0);
    rd_chk("isr_rst", ADDR_ISR, 32'h0);
    rd_chk("cfg_rst", ADDR_CFG, 32'h5);
    rd_chk("tmr_rst", ADDR_TMR, 32'h800);
    wr(ADDR_IMR, 32'h1);
    rd_chk("imr_ro", ADDR_IMR, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk_bit("unmapped_err", 1'b1, perr);
    chk_reg("unmapped_rd", 32'h0, rdata);
    wr(ADDR_LPR, 32'h1);
    rd_chk("lpr_rw", ADDR_LPR, 32'h1);
    wr(ADDR_LPR, 32'h0);
    $display("test registers done");
    repeat (300) @(posedge core_clk);
    sr_cycle(4'h5, 1'b0);
    sr_cycle(4'h0, 1'b1);
    sr_cycle(4'h1, 1'b1);
    sr_cycle(4'hf, 1'b1);
    $display("test self refresh done");
    wr(ADDR_CFG, 32'h3);
    pd0 = n_pd;
    access();
    chk_reg("lp_off_pd", pd0, n_pd);
    chk_bit("lp_off_cke", 1'b1, cke);
    wr(ADDR_LPR, 32'h1);
    access();
    chk_reg("lp_on_pd", pd0 + 8'h01, n_pd);
    chk_bit("lp_on_cke", 1'b0, cke);
    rd_chk("mode_pd", ADDR_MODE, 32'h1);
    access();
    chk_reg("lp_exit_gap", 32'h6, gap);
    chk_reg("lp_again_pd", pd0 + 8'h02, n_pd);
    chk_bit("lp_again_cke", 1'b0, cke);
    chk_bit("acc_busy_low", 1'b0, busy);
    wr(ADDR_LPR, 32'h0);
    access();
    chk_reg("lp_cleared_pd", pd0 + 8'h02, n_pd);
    chk_bit("lp_cleared_cke", 1'b1, cke);
    $display("test low power done");
    chk_reg("ref_off", 32'h0, n_ref);
    wr(ADDR_TMR, 32'h1);
    repeat (3000) @(posedge core_clk);
    chk_bit("ref_seen", 1'b1, n_ref != 8'h00);
    chk_bit("irq_masked", 1'b0, irq);
    wr(ADDR_IER, 32'h0);
    rd_chk("ier_zero", ADDR_IMR, 32'h0);
    wr(ADDR_IER, 32'h1);
    rd_chk("ier_one", ADDR_IMR, 32'h1);
    repeat (3) @(posedge core_clk);
    chk_bit("irq_on", 1'b1, irq);
    wr(ADDR_IDR, 32'h0);
    rd_chk("idr_zero", ADDR_IMR, 32'h1);
    wr(ADDR_IDR, 32'h1);
    rd_chk("idr_one", ADDR_IMR, 32'h0);
    repeat (3) @(posedge core_clk);
    chk_bit("irq_off", 1'b0, irq);
    rd_chk("isr_set", ADDR_ISR, 32'h1);
    wr(ADDR_TMR, 32'hfff);
    repeat (3000) @(posedge core_clk);
    apb(1'b0, ADDR_ISR, 32'h0);
    repeat (100) @(posedge core_clk);
    rd_chk("isr_cleared", ADDR_ISR, 32'h0);
    wr(ADDR_IER, 32'h1);
    repeat (3) @(posedge core_clk);
    chk_bit("irq_no_status", 1'b0, irq);
    $display("test refresh error done");
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule // sdpr_ctrl_tb
